//--- core/kms_col_seq.sv
`timescale 1ns/10ps

`include "kms_regs.svh"

module kms_col_seq
  import kms_pkg::*;
#(
  parameter int unsigned MAX_COLS = `KMS_MAX_COLS
)
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        enable,
  input  wire logic [2:0]  colCount,
  input  wire logic [14:0] order,
  input  wire logic        stepTick,
  output      logic [4:0]  colDrive,
  output      logic        roundDone
);

  kms_seq_s   s;
  kms_seq_s   next_s;
  logic [2:0] effCount;
  logic [2:0] nextSlot;

  ////////////////////////////////////////////////////////////////////////////////
  // Slot field and column decode
  function automatic logic [2:0] slotField(input logic [14:0] ord, input logic [2:0] idx);
    logic [2:0] v;
    case (idx)
      3'h0:    v = ord[2:0];
      3'h1:    v = ord[5:3];
      3'h2:    v = ord[8:6];
      3'h3:    v = ord[11:9];
      3'h4:    v = ord[14:12];
      default: v = 3'h7;
    endcase
    return v;
  endfunction

  function automatic logic [4:0] colOneHot(input logic [2:0] v);
    logic [4:0] m;
    m = 5'h00;
    if (32'(v) < MAX_COLS)
      m[v] = 1'b1;
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Slot stepping
  always_comb
  begin
    next_s = s;
    next_s.roundDone = 1'b0;
    effCount = (32'(colCount) > MAX_COLS) ? 3'(MAX_COLS) : colCount;
    nextSlot = s.slot;
    case (s.state)
      SEQ_IDLE:
      begin
        nextSlot = 3'h0;
        if (enable && effCount != 3'h0)
          next_s.state = SEQ_RUN;
      end
      SEQ_RUN:
      begin
        if (!enable || effCount == 3'h0)
        begin
          next_s.state = SEQ_IDLE;
          nextSlot = 3'h0;
        end
        else if (stepTick || s.slot >= effCount)
        begin
          if (s.slot + 3'h1 >= effCount)
          begin
            nextSlot = 3'h0;
            next_s.roundDone = 1'b1;
          end
          else
            nextSlot = s.slot + 3'h1;
        end
      end
      default: next_s.state = SEQ_IDLE;
    endcase
    next_s.slot = nextSlot;
    next_s.colDrive = (next_s.state == SEQ_RUN) ? colOneHot(slotField(order, nextSlot)) : 5'h00;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      s <= '0;
    else
      s <= next_s;
  end

  assign colDrive  = s.colDrive;
  assign roundDone = s.roundDone;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_slot_wrap: assert property (@(posedge sys_clk) disable iff (srst)
    (s.state == SEQ_RUN && enable && effCount != 3'h0 && s.slot >= effCount) |=> (s.slot == 3'h0))
    else $error("slot beyond column count did not wrap");
  chk_col_decode: assert property (@(posedge sys_clk) disable iff (srst)
    (s.state == SEQ_RUN) |-> (colDrive == colOneHot(slotField($past(order), s.slot))))
    else $error("driven column does not match slot value");
  chk_bad_slot: assert property (@(posedge sys_clk) disable iff (srst)
    (s.state == SEQ_RUN && slotField($past(order), s.slot) > 3'h4) |-> (colDrive == 5'h00))
    else $error("out of range slot drove a column");
  chk_idle_quiet: assert property (@(posedge sys_clk) disable iff (srst)
    (!enable) |=> (colDrive == 5'h00))
    else $error("columns driven with scanning disabled");

endmodule // kms_col_seq

//--- core/kms_pkg.sv
`include "kms_regs.svh"

package kms_pkg;

  typedef struct packed {
    logic [`KMS_ADDR_W-1:0] awaddr;
    logic                   awvalid;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   wvalid;
    logic                   bready;
    logic [`KMS_ADDR_W-1:0] araddr;
    logic                   arvalid;
    logic                   rready;
  } kms_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } kms_axi_rsp_s;

  typedef enum logic [2:0] {
    REG_NONE       = 3'b000,
    REG_SCAN_CTRL  = 3'b001,
    REG_DIMS       = 3'b010,
    REG_ORDER_LOW  = 3'b011,
    REG_ORDER_HIGH = 3'b100,
    REG_IRQ_CTRL   = 3'b101,
    REG_IRQ_STATUS = 3'b110,
    REG_IRQ_MASK   = 3'b111
  } kms_reg_e;

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN  = 1'b1
  } kms_seq_e;

  typedef struct packed {
    kms_seq_e   state;
    logic [2:0] slot;
    logic [4:0] colDrive;
    logic       roundDone;
  } kms_seq_s;

  typedef struct packed {
    kms_axi_rsp_s           rsp;
    logic [`KMS_ADDR_W-1:0] awAddr;
    logic                   awHeld;
    logic [7:0]             wData;
    logic                   wStrb0;
    logic                   wHeld;
    logic                   autoScan;
    logic                   keyFound;
    logic [7:0]             dims;
    logic [7:0]             orderLow;
    logic [7:0]             orderHigh;
    logic                   powerdown_mux_select;
    logic                   irqEnable;
    logic                   irqPending;
    logic [1:0]             irqStatus;
    logic [1:0]             irqMask;
    logic                   irqOut;
    logic [5:0]             rowEnable;
    logic [31:0]            tickCnt;
    logic                   stepTick;
  } kms_top_s;

endpackage

//--- core/kms_regs.svh
`ifndef KMS_REGS_SVH
`define KMS_REGS_SVH
// Overview of operation
// - A 3-bit row count selects how many of up to six rows are scanned.
// - A 3-bit column count limits scanned columns to at most five.
// - Scan order holds five 3-bit slots, each naming a column pin.
// - Auto scan steps slots first to fifth, wrapping back to the first at column count.
// - Order splits: low byte slots one, two, third low bits; high byte rest.
// - Keypad interrupt reaches the processor only while its enable bit is set.
// - Pending flag sets when key found sets; reading its register clears it.
// - Auto scan enable runs hardware scanning; otherwise size settings are ignored.
// - A debounced key press sets key found; reading its register clears it.

////////////////////////////////////////////////////////////////////////////////
// Register indices; byte address is four times the index
`define KMS_ADDR_W          18
`define KMS_IDX_SCAN_CTRL   16'h00D4
`define KMS_IDX_DIMS        16'h00D5
`define KMS_IDX_ORDER_LOW   16'h00D6
`define KMS_IDX_ORDER_HIGH  16'h00D7
`define KMS_IDX_IRQ_STATUS  16'h00E0
`define KMS_IDX_IRQ_MASK    16'h00E1
`define KMS_IDX_IRQ_CTRL    16'hFF94

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define KMS_KEY_FOUND_BIT   1
`define KMS_AUTO_SCAN_BIT   2
`define KMS_COL_COUNT_LSB   0
`define KMS_ROW_COUNT_LSB   3
`define KMS_IRQ_PEND_BIT    0
`define KMS_IRQ_EN_BIT      1
`define KMS_PWRDN_MUX_BIT   7
`define KMS_EVT_KEY_BIT     0
`define KMS_EVT_ROUND_BIT   1

////////////////////////////////////////////////////////////////////////////////
// Reset values, responses, sizes and timing
`define KMS_REG_RESET       8'h00
`define KMS_RESP_OKAY       2'h0
`define KMS_RESP_SLVERR     2'h2
`define KMS_MAX_ROWS        6
`define KMS_MAX_COLS        5
`define KMS_CLK_PERIOD_NS   10
`define KMS_SCAN_STEP_NS    1000000
`define KMS_SCAN_STEP_CYC   (`KMS_SCAN_STEP_NS / `KMS_CLK_PERIOD_NS)

`endif

//--- core/kms_scan_config.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps

`include "kms_regs.svh"

module kms_scan_config
  import kms_pkg::*;
#(
  parameter int unsigned SCAN_STEP_CYC = `KMS_SCAN_STEP_CYC,
  parameter int unsigned MAX_ROWS      = `KMS_MAX_ROWS,
  parameter int unsigned MAX_COLS      = `KMS_MAX_COLS
)
(
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire kms_axi_req_s axiReq,
  output      kms_axi_rsp_s axiRsp,
  input  wire logic         keyFoundPulse,
  output      logic [5:0]   rowEnable,
  output      logic [4:0]   colDrive,
  output      logic         autoScanMode,
  output      logic         powerdownMuxSelect,
  output      logic         keypadIrq
);

  kms_top_s  s;
  kms_top_s  next_s;
  kms_reg_e  wrSel;
  kms_reg_e  rdSel;
  logic      doWrite;
  logic      doRead;
  logic      roundDone;
  logic [7:0] rdByte;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode and row mask
  function automatic kms_reg_e decodeReg(input logic [`KMS_ADDR_W-1:0] addr);
    kms_reg_e r;
    if (addr[1:0] != 2'h0)
      r = REG_NONE;
    else if (addr[`KMS_ADDR_W-1:2] == `KMS_IDX_SCAN_CTRL)
      r = REG_SCAN_CTRL;
    else if (addr[`KMS_ADDR_W-1:2] == `KMS_IDX_DIMS)
      r = REG_DIMS;
    else if (addr[`KMS_ADDR_W-1:2] == `KMS_IDX_ORDER_LOW)
      r = REG_ORDER_LOW;
    else if (addr[`KMS_ADDR_W-1:2] == `KMS_IDX_ORDER_HIGH)
      r = REG_ORDER_HIGH;
    else if (addr[`KMS_ADDR_W-1:2] == `KMS_IDX_IRQ_CTRL)
      r = REG_IRQ_CTRL;
    else if (addr[`KMS_ADDR_W-1:2] == `KMS_IDX_IRQ_STATUS)
      r = REG_IRQ_STATUS;
    else if (addr[`KMS_ADDR_W-1:2] == `KMS_IDX_IRQ_MASK)
      r = REG_IRQ_MASK;
    else
      r = REG_NONE;
    return r;
  endfunction

  function automatic logic [5:0] rowMask(input logic [2:0] count);
    logic [5:0] m;
    m = 6'h00;
    for (int i = 0; i < 6; i++)
      m[i] = (i < int'(count)) && (i < int'(MAX_ROWS));
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Column sequencer
  kms_col_seq #(
    .MAX_COLS (MAX_COLS)
  ) u_kms_col_seq (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .enable    (s.autoScan),
    .colCount  (s.dims[`KMS_COL_COUNT_LSB +: 3]),
    .order     ({s.orderHigh[6:0], s.orderLow}),
    .stepTick  (s.stepTick),
    .colDrive  (colDrive),
    .roundDone (roundDone)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register file, bus slave and events
  always_comb
  begin
    next_s  = s;
    wrSel   = decodeReg(s.awAddr);
    rdSel   = decodeReg(axiReq.araddr);
    doWrite = s.awHeld && s.wHeld && !s.rsp.bvalid;
    doRead  = s.rsp.arready && axiReq.arvalid;
    rdByte  = `KMS_REG_RESET;

    if (s.rsp.bvalid && axiReq.bready)
      next_s.rsp.bvalid = 1'b0;
    if (s.rsp.rvalid && axiReq.rready)
      next_s.rsp.rvalid = 1'b0;
    if (s.rsp.awready && axiReq.awvalid)
    begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = axiReq.awaddr;
    end
    if (s.rsp.wready && axiReq.wvalid)
    begin
      next_s.wHeld  = 1'b1;
      next_s.wData  = axiReq.wdata[7:0];
      next_s.wStrb0 = axiReq.wstrb[0];
    end

    if (doWrite)
    begin
      next_s.awHeld    = 1'b0;
      next_s.wHeld     = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = (wrSel == REG_NONE) ? `KMS_RESP_SLVERR : `KMS_RESP_OKAY;
      if (s.wStrb0)
      begin
        if (wrSel == REG_SCAN_CTRL)
          next_s.autoScan = s.wData[`KMS_AUTO_SCAN_BIT];
        else if (wrSel == REG_DIMS)
          next_s.dims = {2'h0, s.wData[5:0]};
        else if (wrSel == REG_ORDER_LOW)
          next_s.orderLow = s.wData;
        else if (wrSel == REG_ORDER_HIGH)
          next_s.orderHigh = {1'b0, s.wData[6:0]};
        else if (wrSel == REG_IRQ_CTRL)
        begin
          next_s.powerdown_mux_select     = s.wData[`KMS_PWRDN_MUX_BIT];
          next_s.irqEnable = s.wData[`KMS_IRQ_EN_BIT];
        end
        else if (wrSel == REG_IRQ_STATUS)
          next_s.irqStatus = s.irqStatus & ~s.wData[1:0];
        else if (wrSel == REG_IRQ_MASK)
          next_s.irqMask = s.wData[1:0];
      end
    end

    if (doRead)
    begin
      if (rdSel == REG_SCAN_CTRL)
      begin
        rdByte[`KMS_AUTO_SCAN_BIT] = s.autoScan;
        rdByte[`KMS_KEY_FOUND_BIT] = s.keyFound;
        next_s.keyFound = 1'b0;
      end
      else if (rdSel == REG_DIMS)
        rdByte = s.dims;
      else if (rdSel == REG_ORDER_LOW)
        rdByte = s.orderLow;
      else if (rdSel == REG_ORDER_HIGH)
        rdByte = s.orderHigh;
      else if (rdSel == REG_IRQ_CTRL)
      begin
        rdByte[`KMS_PWRDN_MUX_BIT] = s.powerdown_mux_select;
        rdByte[`KMS_IRQ_EN_BIT]   = s.irqEnable;
        rdByte[`KMS_IRQ_PEND_BIT] = s.irqPending;
        next_s.irqPending = 1'b0;
      end
      else if (rdSel == REG_IRQ_STATUS)
        rdByte = {6'h00, s.irqStatus};
      else if (rdSel == REG_IRQ_MASK)
        rdByte = {6'h00, s.irqMask};
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata  = {24'h000000, rdByte};
      next_s.rsp.rresp  = (rdSel == REG_NONE) ? `KMS_RESP_SLVERR : `KMS_RESP_OKAY;
    end

    // Events win over clears in the same cycle
    if (keyFoundPulse)
    begin
      next_s.keyFound   = 1'b1;
      next_s.irqPending = 1'b1;
      next_s.irqStatus[`KMS_EVT_KEY_BIT] = 1'b1;
    end
    if (roundDone)
      next_s.irqStatus[`KMS_EVT_ROUND_BIT] = 1'b1;

    // Scan step timer
    next_s.stepTick = 1'b0;
    if (!s.autoScan)
      next_s.tickCnt = 32'h00000000;
    else if (s.tickCnt >= SCAN_STEP_CYC - 1)
    begin
      next_s.tickCnt  = 32'h00000000;
      next_s.stepTick = 1'b1;
    end
    else
      next_s.tickCnt = s.tickCnt + 32'h00000001;

    next_s.rsp.awready = !next_s.awHeld && !next_s.rsp.bvalid;
    next_s.rsp.wready  = !next_s.wHeld && !next_s.rsp.bvalid;
    next_s.rsp.arready = !next_s.rsp.rvalid;
    next_s.rowEnable   = s.autoScan ? rowMask(s.dims[`KMS_ROW_COUNT_LSB +: 3]) : 6'h3F;
    next_s.irqOut      = s.irqEnable && (s.irqPending || (|(s.irqStatus & s.irqMask)));
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      s <= '0;
    else
      s <= next_s;
  end

  assign axiRsp             = s.rsp;
  assign rowEnable          = s.rowEnable;
  assign autoScanMode       = s.autoScan;
  assign powerdownMuxSelect = s.powerdown_mux_select;
  assign keypadIrq          = s.irqOut;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  chk_irq_gate: assert property (!s.irqEnable |=> !keypadIrq)
    else $error("interrupt raised while disabled");
  chk_irq_raise: assert property ((s.irqEnable && s.irqPending) |=> keypadIrq)
    else $error("enabled pending interrupt not raised");
  chk_pend_set: assert property (keyFoundPulse |=> (s.irqPending && s.keyFound))
    else $error("key event lost");
  chk_pend_clear: assert property ((doRead && rdSel == REG_IRQ_CTRL && !keyFoundPulse) |=> !s.irqPending)
    else $error("pending flag not cleared by read");
  chk_key_clear: assert property ((doRead && rdSel == REG_SCAN_CTRL && !keyFoundPulse) |=> !s.keyFound)
    else $error("key found flag not cleared by read");
  chk_bypass_rows: assert property (!s.autoScan |=> (rowEnable == 6'h3F))
    else $error("size applied in bypass mode");
  chk_row_limit: assert property ((s.autoScan && s.dims[5:3] == 3'h3) |=> (rowEnable == 6'h07))
    else $error("row count not applied");
  chk_order_write: assert property ((doWrite && s.wStrb0 && wrSel == REG_ORDER_HIGH)
    |=> (s.orderHigh == {1'b0, $past(s.wData[6:0])}))
    else $error("high order register not written");
  chk_dims_write: assert property ((doWrite && s.wStrb0 && wrSel == REG_DIMS)
    |=> (s.dims[2:0] == $past(s.wData[2:0])))
    else $error("column count not written");
  chk_read_hold: assert property ((axiRsp.rvalid && !axiReq.rready) |=> (axiRsp.rvalid && $stable(axiRsp.rdata)))
    else $error("read answer dropped before taken");

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt and flag checks
  chk_irq_status: assert property (
    (s.irqEnable && (|(s.irqStatus & s.irqMask))) |=> keypadIrq)
    else $error("enabled masked status did not interrupt");

  chk_irq_cause: assert property (
    (!s.irqPending && !(|(s.irqStatus & s.irqMask))) |=> !keypadIrq)
    else $error("interrupt raised without a cause");

  chk_irq_enable_write: assert property (
    (doWrite && s.wStrb0 && wrSel == REG_IRQ_CTRL) |=> (s.irqEnable == $past(s.wData[`KMS_IRQ_EN_BIT])))
    else $error("interrupt enable not written");

  chk_powerdown_write: assert property (
    (doWrite && s.wStrb0 && wrSel == REG_IRQ_CTRL) |=> (powerdownMuxSelect == $past(s.wData[`KMS_PWRDN_MUX_BIT])))
    else $error("powerdown select not written");

  chk_pend_hold: assert property (
    (s.irqPending && !(doRead && rdSel == REG_IRQ_CTRL)) |=> s.irqPending)
    else $error("pending flag lost without a read");

  chk_pend_source: assert property (
    (!s.irqPending && !keyFoundPulse) |=> !s.irqPending)
    else $error("pending flag set without a key event");

  chk_pend_read: assert property (
    (doRead && rdSel == REG_IRQ_CTRL) |=> (axiRsp.rdata[`KMS_IRQ_PEND_BIT] == $past(s.irqPending)))
    else $error("pending flag not returned by read");

  chk_key_hold: assert property (
    (s.keyFound && !(doRead && rdSel == REG_SCAN_CTRL)) |=> s.keyFound)
    else $error("key found flag lost without a read");

  chk_key_source: assert property (
    (!s.keyFound && !keyFoundPulse) |=> !s.keyFound)
    else $error("key found flag set without a key event");

  chk_key_read: assert property (
    (doRead && rdSel == REG_SCAN_CTRL) |=> (axiRsp.rdata[`KMS_KEY_FOUND_BIT] == $past(s.keyFound)))
    else $error("key found flag not returned by read");

  chk_status_set: assert property (
    keyFoundPulse |=> s.irqStatus[`KMS_EVT_KEY_BIT])
    else $error("key event status not set");

  chk_round_set: assert property (
    roundDone |=> s.irqStatus[`KMS_EVT_ROUND_BIT])
    else $error("round done status not set");

  chk_status_clear: assert property (
    (doWrite && s.wStrb0 && wrSel == REG_IRQ_STATUS && s.wData[`KMS_EVT_KEY_BIT] && !keyFoundPulse)
    |=> !s.irqStatus[`KMS_EVT_KEY_BIT])
    else $error("key event status not cleared by write");

  ////////////////////////////////////////////////////////////////////////////////
  // Scan configuration checks
  chk_auto_write: assert property (
    (doWrite && s.wStrb0 && wrSel == REG_SCAN_CTRL) |=> (autoScanMode == $past(s.wData[`KMS_AUTO_SCAN_BIT])))
    else $error("auto scan enable not written");

  chk_row_max: assert property (
    (s.autoScan && s.dims[5:3] == 3'h7) |=> (rowEnable == 6'h3F))
    else $error("row count beyond six not limited");

  chk_rows_write: assert property (
    (doWrite && s.wStrb0 && wrSel == REG_DIMS) |=> (s.dims[5:3] == $past(s.wData[5:3])))
    else $error("row count not written");

  chk_order_low: assert property (
    (doWrite && s.wStrb0 && wrSel == REG_ORDER_LOW) |=> (s.orderLow == $past(s.wData)))
    else $error("low order register not written");

  chk_col_onehot: assert property (
    $onehot0(colDrive))
    else $error("more than one column driven");

  chk_col_bypass: assert property (
    !s.autoScan |=> (colDrive == 5'h00))
    else $error("column driven in bypass mode");

  chk_col_none: assert property (
    (s.autoScan && s.dims[2:0] == 3'h0) |=> (colDrive == 5'h00))
    else $error("column driven with zero column count");

  chk_tick_gate: assert property (
    !s.autoScan |=> !s.stepTick)
    else $error("scan step while scanning disabled");

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer checks
  chk_write_answer: assert property (
    (s.awHeld && s.wHeld && !s.rsp.bvalid) |=> axiRsp.bvalid)
    else $error("write response not raised");

  chk_write_error: assert property (
    (doWrite && wrSel == REG_NONE) |=> (axiRsp.bresp == `KMS_RESP_SLVERR))
    else $error("unmapped write not refused");

  chk_write_block: assert property (
    axiRsp.bvalid |-> (!axiRsp.awready && !axiRsp.wready))
    else $error("write channel ready during response");

  chk_read_answer: assert property (
    (axiRsp.arready && axiReq.arvalid) |=> axiRsp.rvalid)
    else $error("read answer not raised");

  chk_read_error: assert property (
    (doRead && rdSel == REG_NONE) |=> (axiRsp.rresp == `KMS_RESP_SLVERR && axiRsp.rdata == 32'h00000000))
    else $error("unmapped read not refused");

  chk_read_upper: assert property (
    axiRsp.rvalid |-> (axiRsp.rdata[31:8] == 24'h000000))
    else $error("upper read data not zero");

  chk_read_block: assert property (
    axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read address ready during answer");

endmodule // kms_scan_config

//--- tb/kms_key_matrix.sv
`timescale 1ns/10ps

module kms_key_matrix
  import kms_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [4:0] colDrive,
  input  wire logic [2:0] pressCol,
  input  wire logic       pressReq,
  output      logic       seen,
  output      logic       keyFoundPulse
);
  // One debounced find per press, only while the pressed column is driven
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      seen          <= 1'b0;
      keyFoundPulse <= 1'b0;
    end
    else
    begin
      keyFoundPulse <= pressReq && !seen && colDrive[pressCol];
      seen          <= pressReq && (seen || colDrive[pressCol]);
    end
  end
endmodule // kms_key_matrix

//--- tb/tb_kms_scan_config.sv
`timescale 1ns/10ps

module tb_kms_scan_config
  import kms_pkg::*;
;
  logic         sys_clk;
  logic         srst;
  kms_axi_req_s axiReq;
  kms_axi_rsp_s axiRsp;
  logic         keyFoundPulse;
  logic [5:0]   rowEnable;
  logic [4:0]   colDrive;
  logic         autoScanMode;
  logic         powerdownMuxSelect;
  logic         keypadIrq;
  logic [2:0]   pressCol;
  logic         pressReq;
  logic         seen;
  int           mismatches;
  int           cmp_count;
  logic [31:0]  rd;
  logic [1:0]   rs;
  logic [1:0]   wrs;
  logic [4:0]   last;
  logic [4:0]   colSeq [4];
  int           n;

  kms_scan_config #(.SCAN_STEP_CYC(8)) u_kms_scan_config (
    .sys_clk(sys_clk), .srst(srst), .axiReq(axiReq), .axiRsp(axiRsp),
    .keyFoundPulse(keyFoundPulse), .rowEnable(rowEnable), .colDrive(colDrive),
    .autoScanMode(autoScanMode), .powerdownMuxSelect(powerdownMuxSelect), .keypadIrq(keypadIrq));

  kms_key_matrix u_kms_key_matrix (
    .sys_clk(sys_clk), .srst(srst), .colDrive(colDrive), .pressCol(pressCol),
    .pressReq(pressReq), .seen(seen), .keyFoundPulse(keyFoundPulse));

  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp_val({30'h0, got}, {30'h0, exp});
  endtask

  task automatic axi_wr(input logic [15:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    axiReq.awaddr  <= {idx, 2'b00};
    axiReq.awvalid <= 1'b1;
    axiReq.wdata   <= {24'h000000, d};
    axiReq.wstrb   <= 4'hF;
    axiReq.wvalid  <= 1'b1;
    axiReq.bready  <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid)
      begin
        wrs = axiRsp.bresp;
        axiReq.bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    axiReq.araddr  <= {idx, 2'b00};
    axiReq.arvalid <= 1'b1;
    axiReq.rready  <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid)
      begin
        d = axiRsp.rdata;
        r = axiRsp.rresp;
        axiReq.rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic chk_rd(input logic [15:0] idx, input logic [7:0] exp);
    axi_rd(idx, rd, rs);
    cmp_resp(rs, 2'h0);
    cmp_val(rd, {24'h000000, exp});
  endtask

  task automatic press(input logic [2:0] c);
    @(posedge sys_clk);
    pressCol <= c;
    pressReq <= 1'b1;
    for (int i = 0; i < 400 && !seen; i++) @(posedge sys_clk);
    pressReq <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic cap_cols();
    last = 5'h00;
    n = 0;
    for (int i = 0; i < 300 && n < 4; i++)
    begin
      @(posedge sys_clk);
      if (colDrive !== last)
      begin
        colSeq[n] = colDrive;
        last = colDrive;
        n++;
      end
    end
  endtask

  task automatic finish_test();
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    mismatches++;
    finish_test();
  end

  initial
  begin
    sys_clk  = 1'b0;
    srst     = 1'b1;
    axiReq   = '0;
    pressCol = 3'h0;
    pressReq = 1'b0;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    // Reset values
    chk_rd(16'h00D4, 8'h00);
    chk_rd(16'h00D5, 8'h00);
    chk_rd(16'h00D6, 8'h00);
    chk_rd(16'h00D7, 8'h00);
    chk_rd(16'hFF94, 8'h00);
    cmp_val({26'h0, rowEnable}, 32'h3F);
    axi_rd(16'h0010, rd, rs);
    cmp_resp(rs, 2'h2);
    cmp_val(rd, 32'h0);
    axi_wr(16'h0010, 8'h55);
    cmp_resp(wrs, 2'h2);
    // Order split and unused top bit
    axi_wr(16'h00D7, 8'hFF);
    cmp_resp(wrs, 2'h0);
    chk_rd(16'h00D7, 8'h7F);
    axi_wr(16'h00D6, 8'h88);
    axi_wr(16'h00D7, 8'h46);
    chk_rd(16'h00D6, 8'h88);
    chk_rd(16'h00D7, 8'h46);
    // Slots 4, 7, 1 with three columns and three rows
    axi_wr(16'h00D6, 8'h7C);
    axi_wr(16'h00D7, 8'h00);
    axi_wr(16'h00D5, 8'h1B);
    chk_rd(16'h00D5, 8'h1B);
    cmp_val({26'h0, rowEnable}, 32'h3F);
    axi_wr(16'h00D4, 8'h04);
    cap_cols();
    cmp_val({27'h0, colSeq[0]}, 32'h10);
    cmp_val({27'h0, colSeq[1]}, 32'h00);
    cmp_val({27'h0, colSeq[2]}, 32'h02);
    cmp_val({27'h0, colSeq[3]}, 32'h10);
    cmp_val({26'h0, rowEnable}, 32'h07);
    cmp_val({31'h0, autoScanMode}, 32'h1);
    // Key found with interrupt disabled
    press(3'h1);
    cmp_val({31'h0, keypadIrq}, 32'h0);
    chk_rd(16'hFF94, 8'h01);
    chk_rd(16'hFF94, 8'h00);
    chk_rd(16'h00D4, 8'h06);
    chk_rd(16'h00D4, 8'h04);
    axi_rd(16'h00E0, rd, rs);
    cmp_val(rd & 32'h1, 32'h1);
    axi_wr(16'h00E0, 8'h03);
    // Enabled interrupt, pending cleared by read
    axi_wr(16'hFF94, 8'h82);
    cmp_val({31'h0, powerdownMuxSelect}, 32'h1);
    press(3'h1);
    cmp_val({31'h0, keypadIrq}, 32'h1);
    chk_rd(16'hFF94, 8'h83);
    // Handler reloads ascending order and restarts the scan
    axi_wr(16'h00D6, 8'h88);
    axi_wr(16'h00D7, 8'h46);
    axi_wr(16'h00D4, 8'h00);
    axi_wr(16'h00D4, 8'h04);
    cap_cols();
    cmp_val({27'h0, colSeq[0]}, 32'h01);
    cmp_val({27'h0, colSeq[1]}, 32'h02);
    cmp_val({27'h0, colSeq[2]}, 32'h04);
    cmp_val({27'h0, colSeq[3]}, 32'h01);
    repeat (3) @(posedge sys_clk);
    cmp_val({31'h0, keypadIrq}, 32'h0);
    // Masked status path
    axi_wr(16'h00E1, 8'h01);
    repeat (3) @(posedge sys_clk);
    cmp_val({31'h0, keypadIrq}, 32'h1);
    axi_wr(16'h00E0, 8'h01);
    repeat (3) @(posedge sys_clk);
    cmp_val({31'h0, keypadIrq}, 32'h0);
    // Round done status, then rows beyond six and no columns
    axi_wr(16'h00E1, 8'h02);
    repeat (30) @(posedge sys_clk);
    cmp_val({31'h0, keypadIrq}, 32'h1);
    axi_wr(16'h00D5, 8'h38);
    axi_wr(16'h00E0, 8'h02);
    repeat (3) @(posedge sys_clk);
    cmp_val({31'h0, keypadIrq}, 32'h0);
    cmp_val({26'h0, rowEnable}, 32'h3F);
    cmp_val({27'h0, colDrive}, 32'h00);
    // Turning scanning off returns to bypass
    axi_wr(16'h00D4, 8'h00);
    repeat (3) @(posedge sys_clk);
    cmp_val({26'h0, rowEnable}, 32'h3F);
    cmp_val({27'h0, colDrive}, 32'h00);
    finish_test();
  end
endmodule // tb_kms_scan_config
